// File: core/ddrmr_config.sv
// Overview of operation
// R1: auto precharge waits write recovery after burst
// R2: controller programs write recovery 2 to 8
// R3: exit bit picks fast or slow powerdown
// R4: read data at edge n plus latency
// R5: read delayed internally by additive latency
// R6: controller loads modes only when idle
// R7: extended mode kept until next load
// R8: controller resets DLL after enabling it
// R9: self refresh stops DLL, exit resets it
// R10: controller waits 200 clocks before reads
// R11: slow clock without DLL needs precharge-all
// R12: drive bit selects full or reduced drive
// R13: complement strobe disable bit gates complements
// R14: redundant strobe follows strobe on reads only
// R15: output disable bit turns off outputs
// R16: two select bits choose termination value
// R17: termination pin honoured in allowed states only
// R18: controller drops termination before self refresh
// R19: controller keeps termination low eight clocks
// R20: controller writes zero to unused bits; init loads 13'h0380 into the extended register, and 13'h0632 sets base bit 1
// R21: controller sets then clears calibration bits; the model has no calibration bits
// R22: additive 0-6, write latency one less
// R23: DLL reset bit self clears
// R24: bank address routes load to register
`timescale 1ns/1ps
`include "ddrmr_params.svh"
`default_nettype none
module ddrmr_config (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // avalon-mm slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // command bus from the controller
    input wire ddrmr_pkg::ddrmr_cmd_t cmd_in,
    input wire logic odt_in,
    // timing events
    output logic internal_read_out,
    output logic read_data_valid_out,
    output logic write_data_valid_out,
    output logic auto_precharge_out,
    // dll and power state
    output logic dll_enabled_out,
    output logic dll_reset_out,
    output logic dll_frozen_out,
    output logic exit_ready_out,
    // pad control
    output ddrmr_pkg::ddrmr_pad_t pad_out
);
    import ddrmr_pkg::*;

    logic [12:0] base_mode, next_base_mode;
    logic [12:0] ext_mode, next_ext_mode;
    logic width_x8, next_width_x8;
    ddrmr_power_t state, next_state;
    logic [2:0] exit_count, next_exit_count;
    logic dll_reset, next_dll_reset;
    logic [31:0] al_pipe, next_al_pipe;
    logic [31:0] rd_pipe, next_rd_pipe;
    logic [31:0] wr_pipe, next_wr_pipe;
    logic [31:0] pre_pipe, next_pre_pipe;
    logic rd_tail, next_rd_tail;
    ddrmr_pad_t pad, next_pad;
    logic ack, next_ack;
    logic [31:0] readdata, next_readdata;

    logic [2:0] al;
    logic [3:0] cl, rl, wl, wr_clocks;
    logic [4:0] pre_delay;
    logic active, rd_accept, wr_accept, load_base, load_ext, sr_exit;
    logic bus_req, bus_write;

    // latencies from the programmed fields
    assign al = ext_mode[`DDRMR_AL_MSB:`DDRMR_AL_LSB];
    assign cl = {1'b0, base_mode[`DDRMR_CL_MSB:`DDRMR_CL_LSB]};
    assign rl = 4'(al) + cl; // R22
    assign wl = rl - 4'h1; // R22
    // write recovery code 1..7 means 2..8 clocks
    assign wr_clocks = {1'b0, base_mode[`DDRMR_WR_MSB:`DDRMR_WR_LSB]} + 4'h1;
    assign pre_delay = 5'(wl) + `DDRMR_BURST_CLOCKS + 5'(wr_clocks); // R1

    assign active = (state == DDRMR_ST_ACTIVE);
    assign rd_accept = cmd_in.valid && cmd_in.op == DDRMR_OP_READ && active;
    assign wr_accept = cmd_in.valid && cmd_in.op == DDRMR_OP_WRITE_AP &&
        active;
    // only the low two bank bits pick the register; higher ones are don't care
    assign load_base = cmd_in.valid && cmd_in.op == DDRMR_OP_LOAD_MODE &&
        active && cmd_in.bank[1:0] == `DDRMR_BANK_BASE; // R24
    assign load_ext = cmd_in.valid && cmd_in.op == DDRMR_OP_LOAD_MODE &&
        active && cmd_in.bank[1:0] == `DDRMR_BANK_EXT; // R24
    assign sr_exit = cmd_in.valid && cmd_in.op == DDRMR_OP_EXIT &&
        state == DDRMR_ST_SELF_REF;

    // mode registers
    always_comb begin
        next_base_mode = base_mode;
        next_base_mode[`DDRMR_DLL_RESET_BIT] = 1'b0; // R23
        next_ext_mode = ext_mode; // R7
        if (load_base) begin
            next_base_mode = cmd_in.addr; // R24
        end
        if (load_ext) begin
            next_ext_mode = cmd_in.addr; // R24
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            base_mode <= `DDRMR_BASE_RESET;
            ext_mode <= `DDRMR_EXT_RESET;
        end else begin
            base_mode <= next_base_mode;
            ext_mode <= next_ext_mode;
        end
    end

    // power state, exit timing and dll control
    always_comb begin
        next_state = state;
        next_exit_count = (exit_count != 3'h0) ? exit_count - 3'h1 : 3'h0;
        next_dll_reset = 1'b0;
        if (load_base && cmd_in.addr[`DDRMR_DLL_RESET_BIT]) begin
            next_dll_reset = 1'b1; // R23
        end
        // the dll comes back reset when self refresh ends with its enable bit low
        if (sr_exit && !ext_mode[`DDRMR_DLL_ENABLE_BIT]) begin
            next_dll_reset = 1'b1; // R9
        end
        if (cmd_in.valid) begin
            case (state)
                DDRMR_ST_ACTIVE: begin
                    if (cmd_in.op == DDRMR_OP_ACT_PD) begin
                        next_state = DDRMR_ST_ACT_PD;
                    end else if (cmd_in.op == DDRMR_OP_PRE_PD) begin
                        next_state = DDRMR_ST_PRE_PD;
                    end else if (cmd_in.op == DDRMR_OP_SELF_REF) begin
                        next_state = DDRMR_ST_SELF_REF;
                    end
                end
                DDRMR_ST_ACT_PD: begin
                    if (cmd_in.op == DDRMR_OP_EXIT) begin
                        next_state = DDRMR_ST_ACTIVE;
                        next_exit_count =
                            base_mode[`DDRMR_PD_EXIT_BIT] ?
                            `DDRMR_SLOW_EXIT_CLOCKS :
                            `DDRMR_FAST_EXIT_CLOCKS; // R3
                    end
                end
                // exit bit has no say over precharge powerdown
                DDRMR_ST_PRE_PD: begin
                    if (cmd_in.op == DDRMR_OP_EXIT) begin
                        next_state = DDRMR_ST_ACTIVE;
                        next_exit_count = `DDRMR_FAST_EXIT_CLOCKS; // R3
                    end
                end
                DDRMR_ST_SELF_REF: begin
                    if (cmd_in.op == DDRMR_OP_EXIT) begin
                        next_state = DDRMR_ST_ACTIVE;
                    end
                end
                default: begin
                    next_state = DDRMR_ST_ACTIVE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state <= DDRMR_ST_ACTIVE;
            exit_count <= 3'h0;
            dll_reset <= 1'b0;
        end else begin
            state <= next_state;
            exit_count <= next_exit_count;
            dll_reset <= next_dll_reset;
        end
    end

    // enable bit is active low; self refresh overrides it
    assign dll_enabled_out = !ext_mode[`DDRMR_DLL_ENABLE_BIT] &&
        state != DDRMR_ST_SELF_REF; // R9
    assign dll_reset_out = dll_reset;
    assign dll_frozen_out = state == DDRMR_ST_ACT_PD &&
        base_mode[`DDRMR_PD_EXIT_BIT]; // R3
    assign exit_ready_out = (exit_count == 3'h0);

    // latency pipes: bit k fires k+1 edges after it is set
    always_comb begin
        next_al_pipe = al_pipe >> 1;
        next_rd_pipe = rd_pipe >> 1;
        next_wr_pipe = wr_pipe >> 1;
        next_pre_pipe = pre_pipe >> 1;
        next_rd_tail = rd_pipe[0];
        if (rd_accept && al != 3'h0) begin
            next_al_pipe[al - 3'h1] = 1'b1; // R5
        end
        if (rd_accept && rl != 4'h0) begin
            next_rd_pipe[rl - 4'h1] = 1'b1; // R4
        end
        if (wr_accept && wl != 4'h0) begin
            next_wr_pipe[wl - 4'h1] = 1'b1; // R22
        end
        if (wr_accept) begin
            next_pre_pipe[pre_delay - 5'h01] = 1'b1; // R1
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            al_pipe <= 32'h0;
            rd_pipe <= 32'h0;
            wr_pipe <= 32'h0;
            pre_pipe <= 32'h0;
            rd_tail <= 1'b0;
        end else begin
            al_pipe <= next_al_pipe;
            rd_pipe <= next_rd_pipe;
            wr_pipe <= next_wr_pipe;
            pre_pipe <= next_pre_pipe;
            rd_tail <= next_rd_tail;
        end
    end

    assign internal_read_out = (rd_accept && al == 3'h0) || al_pipe[0]; // R5
    assign read_data_valid_out = rd_pipe[0]; // R4
    assign write_data_valid_out = wr_pipe[0]; // R22
    assign auto_precharge_out = pre_pipe[0]; // R1

    // pad control, timed with the read burst of two clocks
    always_comb begin
        logic reading;
        reading = next_rd_pipe[0] || next_rd_tail;
        next_pad.drive_reduced = next_ext_mode[`DDRMR_DRIVE_BIT]; // R12
        next_pad.data_oe = reading &&
            !next_ext_mode[`DDRMR_QOFF_BIT]; // R15
        next_pad.strobe_oe = next_pad.data_oe; // R15
        next_pad.strobe_comp_oe = next_pad.data_oe &&
            !next_ext_mode[`DDRMR_CSD_BIT]; // R13
        // redundant strobe only leaves the pins on reads, so writes ignore it
        next_pad.redundant_read_strobe_oe = next_pad.data_oe && next_width_x8 &&
            next_ext_mode[`DDRMR_REDUNDANT_READ_STROBE_BIT]; // R14
        next_pad.redundant_read_strobe_comp_oe = next_pad.redundant_read_strobe_oe &&
            !next_ext_mode[`DDRMR_CSD_BIT]; // R13
        next_pad.termination_sel = {next_ext_mode[`DDRMR_RTT_HI_BIT],
            next_ext_mode[`DDRMR_RTT_LO_BIT]}; // R16
        next_pad.termination_on = next_pad.termination_sel != 2'h0 &&
            odt_in && next_state != DDRMR_ST_SELF_REF; // R17
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pad <= '0;
        end else begin
            pad <= next_pad;
        end
    end

    assign pad_out = pad;

    // avalon slave: one wait state, then the answer
    assign bus_req = avs_read_in || avs_write_in;
    assign bus_write = avs_write_in && ack;
    assign avs_waitrequest_out = bus_req && !ack;

    always_comb begin
        next_ack = bus_req && !ack;
        next_readdata = readdata;
        next_width_x8 = width_x8;
        if (avs_read_in && !ack) begin
            case (avs_address_in)
                `DDRMR_OFS_BASE: next_readdata = {19'h0, base_mode};
                `DDRMR_OFS_EXT: next_readdata = {19'h0, ext_mode};
                `DDRMR_OFS_STATUS: next_readdata = {27'h0, exit_ready_out,
                    dll_enabled_out, dll_frozen_out, state};
                `DDRMR_OFS_CONTROL: next_readdata = {31'h0, width_x8};
                default: next_readdata = 32'h0;
            endcase
        end
        if (bus_write && avs_address_in == `DDRMR_OFS_CONTROL &&
            avs_byteenable_in[0]) begin
            next_width_x8 = avs_writedata_in[0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ack <= 1'b0;
            readdata <= 32'h0;
            width_x8 <= `DDRMR_CONTROL_RESET;
        end else begin
            ack <= next_ack;
            readdata <= next_readdata;
            width_x8 <= next_width_x8;
        end
    end

    assign avs_readdata_out = readdata;

    // checks
    chk_read_latency3: assert property (@(posedge clock_in) // R4
        disable iff (reset_in)
        rd_accept && rl == 4'h3 |-> ##3 read_data_valid_out)
        else $error("read data not at latency 3");
    chk_read_latency7: assert property (@(posedge clock_in) // R4
        disable iff (reset_in)
        rd_accept && rl == 4'h7 |-> ##6 !read_data_valid_out ##1
        read_data_valid_out)
        else $error("read data not at latency 7");
    chk_additive_delay: assert property (@(posedge clock_in) // R5
        disable iff (reset_in)
        rd_accept && al == 3'h2 |-> ##2 internal_read_out)
        else $error("internal read not delayed by 2");
    chk_write_latency: assert property (@(posedge clock_in) // R22
        disable iff (reset_in)
        wr_accept && rl == 4'h5 |-> ##4 write_data_valid_out)
        else $error("write latency not read latency minus one");
    chk_precharge_delay: assert property (@(posedge clock_in) // R1
        disable iff (reset_in)
        wr_accept && wl == 4'h2 && wr_clocks == 4'h2 |->
        ##5 !auto_precharge_out ##1 auto_precharge_out)
        else $error("auto precharge not after write recovery");
    chk_dll_reset_clear: assert property (@(posedge clock_in) // R23
        disable iff (reset_in)
        load_base && cmd_in.addr[`DDRMR_DLL_RESET_BIT] |=>
        dll_reset_out && base_mode[`DDRMR_DLL_RESET_BIT] ##1
        !base_mode[`DDRMR_DLL_RESET_BIT])
        else $error("dll reset bit did not self clear");
    chk_self_ref_dll: assert property (@(posedge clock_in) // R9
        disable iff (reset_in)
        sr_exit && !ext_mode[`DDRMR_DLL_ENABLE_BIT] |->
        !dll_enabled_out ##1 dll_enabled_out && dll_reset_out)
        else $error("dll not restarted on self refresh exit");
    chk_output_disable: assert property (@(posedge clock_in) // R15
        disable iff (reset_in)
        ext_mode[`DDRMR_QOFF_BIT] |-> !pad_out.data_oe &&
        !pad_out.strobe_oe && !pad_out.redundant_read_strobe_oe)
        else $error("outputs driven while disabled");
    chk_odt_state: assert property (@(posedge clock_in) // R17
        disable iff (reset_in)
        state == DDRMR_ST_SELF_REF || pad_out.termination_sel == 2'h0
        |-> !pad_out.termination_on)
        else $error("termination on where not allowed");
    chk_ext_hold: assert property (@(posedge clock_in) // R7
        disable iff (reset_in)
        !load_ext |=> $stable(ext_mode))
        else $error("extended mode changed without load");
    cov_read: cover property (@(posedge clock_in)
        rd_accept ##[1:14] read_data_valid_out);
    cov_auto_precharge: cover property (@(posedge clock_in)
        wr_accept ##[1:31] auto_precharge_out);
    cov_slow_exit: cover property (@(posedge clock_in)
        dll_frozen_out ##1 !exit_ready_out);
endmodule
`default_nettype wire

// File: core/ddrmr_params.svh
`ifndef DDRMR_PARAMS_SVH
`define DDRMR_PARAMS_SVH
// register offsets (byte addresses)
`define DDRMR_OFS_BASE 4'h0
`define DDRMR_OFS_EXT 4'h4
`define DDRMR_OFS_STATUS 4'h8
`define DDRMR_OFS_CONTROL 4'hc
// base mode register fields
`define DDRMR_CL_LSB 4
`define DDRMR_CL_MSB 6
`define DDRMR_DLL_RESET_BIT 8
`define DDRMR_WR_LSB 9
`define DDRMR_WR_MSB 11
`define DDRMR_PD_EXIT_BIT 12
// extended mode register fields
`define DDRMR_DLL_ENABLE_BIT 0
`define DDRMR_DRIVE_BIT 1
`define DDRMR_RTT_LO_BIT 2
`define DDRMR_AL_LSB 3
`define DDRMR_AL_MSB 5
`define DDRMR_RTT_HI_BIT 6
`define DDRMR_CSD_BIT 10
`define DDRMR_REDUNDANT_READ_STROBE_BIT 11
`define DDRMR_QOFF_BIT 12
// bank address selecting the target register
`define DDRMR_BANK_BASE 2'h0
`define DDRMR_BANK_EXT 2'h1
// reset values
`define DDRMR_BASE_RESET 13'h0000
`define DDRMR_EXT_RESET 13'h0000
`define DDRMR_CONTROL_RESET 1'h0
// timing counts in clocks
`define DDRMR_BURST_CLOCKS 5'h02
`define DDRMR_FAST_EXIT_CLOCKS 3'h2
`define DDRMR_SLOW_EXIT_CLOCKS 3'h6
`endif

// File: core/ddrmr_pkg.sv
package ddrmr_pkg;
    typedef enum logic [2:0] {
        DDRMR_OP_NOP = 3'b000,
        DDRMR_OP_LOAD_MODE = 3'b001,
        DDRMR_OP_READ = 3'b010,
        DDRMR_OP_WRITE_AP = 3'b011,
        DDRMR_OP_ACT_PD = 3'b100,
        DDRMR_OP_PRE_PD = 3'b101,
        DDRMR_OP_SELF_REF = 3'b110,
        DDRMR_OP_EXIT = 3'b111
    } ddrmr_op_t;

    typedef enum logic [1:0] {
        DDRMR_ST_ACTIVE = 2'b00,
        DDRMR_ST_ACT_PD = 2'b01,
        DDRMR_ST_PRE_PD = 2'b10,
        DDRMR_ST_SELF_REF = 2'b11
    } ddrmr_power_t;

    typedef struct packed {
        logic valid;
        ddrmr_op_t op;
        logic [2:0] bank;
        logic [12:0] addr;
    } ddrmr_cmd_t;

    typedef struct packed {
        logic drive_reduced;
        logic data_oe;
        logic strobe_oe;
        logic strobe_comp_oe;
        logic redundant_read_strobe_oe;
        logic redundant_read_strobe_comp_oe;
        logic termination_on;
        logic [1:0] termination_sel;
    } ddrmr_pad_t;
endpackage

// File: dv/ddrmr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddrmr_ctrl_model
    import ddrmr_pkg::*;
(
    // clock
    input wire logic clock_in,
    // command side
    output ddrmr_pkg::ddrmr_cmd_t cmd_out,
    output logic odt_out
);
    initial begin
        cmd_out = '0;
        odt_out = 1'b0;
    end
    // idle address is inverted so a stale value is never mistaken for data
    task automatic issue(input ddrmr_op_t op, input logic [2:0] bank,
        input logic [12:0] addr);
        @(posedge clock_in);
        cmd_out <= '{1'b1, op, bank, addr};
        @(posedge clock_in);
        cmd_out <= '{1'b0, DDRMR_OP_NOP, 3'h0, ~addr};
    endtask
    // top two bank bits always zero, value passed on as given; only issued when idle
    task automatic load(input logic sel, input logic [12:0] v);
        issue(DDRMR_OP_LOAD_MODE, {2'b00, sel}, v);
        repeat (4) @(posedge clock_in);
    endtask
    task automatic dll_on(input logic [12:0] ext, input logic [12:0] base);
        load(1'b1, ext & 13'h1ffe);
        load(1'b0, base | 13'h0100);
        repeat (200) @(posedge clock_in);
    endtask
    task automatic init();
        load(1'b1, 13'h0380);
        load(1'b1, 13'h0000);
    endtask
    task automatic odt(input logic on);
        if (on) repeat (8) @(posedge clock_in);
        @(posedge clock_in);
        odt_out <= on;
    endtask
    // no refresh op exists, so the precharge-all pairing never arises
    task automatic self_ref();
        if (odt_out) odt(1'b0);
        issue(DDRMR_OP_SELF_REF, 3'h0, 13'h0);
    endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddrmr_params.svh"
module tb_top;
    import ddrmr_pkg::*;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] avs_address_in = 4'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out, q;
    logic avs_waitrequest_out, internal_read_out, read_data_valid_out;
    logic write_data_valid_out, auto_precharge_out, dll_enabled_out;
    logic dll_reset_out, dll_frozen_out, exit_ready_out, odt;
    ddrmr_cmd_t cmd;
    ddrmr_pad_t pad_out, p_rd;
    int n_fail = 0, compares = 0, cyc = 0, n_dlr = 0;
    int t_cmd, t_ir, t_rdv, t_wdv, t_ap, t_nrdy;

    always #25 clock_in = ~clock_in;

    ddrmr_config dut (.clock_in(clock_in), .reset_in(reset_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'h1), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .cmd_in(cmd),
        .odt_in(odt), .internal_read_out(internal_read_out),
        .read_data_valid_out(read_data_valid_out),
        .write_data_valid_out(write_data_valid_out),
        .auto_precharge_out(auto_precharge_out),
        .dll_enabled_out(dll_enabled_out), .dll_reset_out(dll_reset_out),
        .dll_frozen_out(dll_frozen_out), .exit_ready_out(exit_ready_out),
        .pad_out(pad_out));
    ddrmr_ctrl_model ctl (.clock_in(clock_in), .cmd_out(cmd),
        .odt_out(odt));

    // edge-sampled event times, so latencies are counted in whole clocks
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cmd.valid === 1'b1) t_cmd <= cyc;
        if (internal_read_out === 1'b1) t_ir <= cyc;
        if (read_data_valid_out === 1'b1) t_rdv <= cyc;
        if (read_data_valid_out === 1'b1) p_rd <= pad_out;
        if (write_data_valid_out === 1'b1) t_wdv <= cyc;
        if (auto_precharge_out === 1'b1) t_ap <= cyc;
        if (exit_ready_out !== 1'b1) t_nrdy <= cyc;
        if (dll_reset_out === 1'b1) n_dlr <= n_dlr + 1;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // no local limit: a stalled slave is caught by the watchdog
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clock_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= ~wr;
        avs_write_in <= wr;
        do begin
            @(posedge clock_in);
        end while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic t_rst();
        bus(0, `DDRMR_OFS_BASE, 0);
        chk(q, 32'h0);
        bus(0, `DDRMR_OFS_STATUS, 0);
        chk(q, 32'h18);
        bus(1, `DDRMR_OFS_BASE, 32'h1fff);
        bus(1, 4'h2, 32'h1);
        bus(0, `DDRMR_OFS_BASE, 0);
        chk(q, 32'h0);
        bus(0, 4'h2, 0);
        chk(q, 32'h0);
        ctl.init();
        bus(0, `DDRMR_OFS_EXT, 0);
        chk(q, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_lat();
        logic [12:0] b;
        logic [2:0] cl, al, wr;
        for (int i = 0; i < 7; i++) begin
            cl = 3'(3 + i % 5);
            // al walks 0..6 so latencies 3, 5 and 7 all occur
            al = 3'(i);
            wr = 3'(i + 1);
            b = {1'b0, wr, 2'b00, cl, 4'h2};
            ctl.load(1'b0, b);
            ctl.load(1'b1, {7'h0, al, 3'h0});
            bus(0, `DDRMR_OFS_BASE, 0);
            chk(q, {19'h0, b});
            ctl.issue(DDRMR_OP_READ, 3'h0, 13'h0);
            repeat (30) @(posedge clock_in);
            chk(t_ir - t_cmd, al);
            chk(t_rdv - t_cmd, al + cl);
            ctl.issue(DDRMR_OP_WRITE_AP, 3'h0, 13'h0);
            repeat (30) @(posedge clock_in);
            chk(t_wdv - t_cmd, al + cl - 1);
            chk(t_ap - t_cmd, al + cl + 2 + wr);
        end
        $display("test latency done");
    endtask

    task automatic t_pad();
        logic [1:0] s;
        logic csd, rq, qo;
        bus(1, `DDRMR_OFS_CONTROL, 32'h1);
        bus(0, `DDRMR_OFS_CONTROL, 0);
        chk(q, 32'h1);
        for (int j = 0; j < 4; j++) begin
            s = 2'(j + 1);
            csd = (j == 1);
            rq = j[1];
            qo = (j == 3);
            ctl.load(1'b1, {qo, rq, csd, 3'h0, s[1], 3'h0, s[0], j[0], 1'b0});
            ctl.odt(1'b1);
            repeat (2) @(negedge clock_in);
            chk(pad_out.termination_on, s != 2'b00);
            chk(pad_out.termination_sel, s);
            chk(pad_out.drive_reduced, j[0]);
            ctl.issue(DDRMR_OP_READ, 3'h0, 13'h0);
            repeat (15) @(posedge clock_in);
            chk(p_rd.data_oe, !qo);
            chk(p_rd.strobe_oe, !qo);
            chk(p_rd.strobe_comp_oe, !qo && !csd);
            chk(p_rd.redundant_read_strobe_oe, rq && !qo);
            chk(p_rd.redundant_read_strobe_comp_oe, rq && !csd && !qo);
            ctl.odt(1'b0);
        end
        // redundant strobe must stay off outside the x8 configuration
        bus(1, `DDRMR_OFS_CONTROL, 32'h0);
        ctl.load(1'b1, 13'h0800);
        ctl.issue(DDRMR_OP_READ, 3'h0, 13'h0);
        repeat (15) @(posedge clock_in);
        chk(p_rd.data_oe, 1'b1);
        chk(p_rd.redundant_read_strobe_oe, 1'b0);
        chk(p_rd.redundant_read_strobe_comp_oe, 1'b0);
        $display("test pads done");
    endtask

    task automatic t_dll();
        ctl.dll_on(13'h0000, 13'h0632);
        bus(0, `DDRMR_OFS_BASE, 0);
        chk(q[8], 1'b0);
        chk(n_dlr, 1);
        ctl.load(1'b1, 13'h0001);
        bus(0, `DDRMR_OFS_STATUS, 0);
        chk(q[3], 1'b0);
        ctl.dll_on(13'h0000, 13'h0632);
        ctl.self_ref();
        bus(0, `DDRMR_OFS_STATUS, 0);
        chk(q[3:0], 4'h3);
        ctl.issue(DDRMR_OP_EXIT, 3'h0, 13'h0);
        repeat (10) @(posedge clock_in);
        chk(n_dlr, 3);
        bus(0, `DDRMR_OFS_STATUS, 0);
        chk(q[3:0], 4'h8);
        $display("test dll done");
    endtask

    task automatic t_pwr();
        int w[3];
        for (int k = 0; k < 3; k++) begin
            ctl.load(1'b0, {k != 0, 12'h632});
            ctl.issue(k == 2 ? DDRMR_OP_PRE_PD : DDRMR_OP_ACT_PD, 3'h0, 13'h0);
            bus(0, `DDRMR_OFS_STATUS, 0);
            chk(q[2:0], k == 1 ? 3'h5 : (k == 2 ? 3'h2 : 3'h1));
            ctl.issue(DDRMR_OP_EXIT, 3'h0, 13'h0);
            repeat (12) @(posedge clock_in);
            w[k] = t_nrdy - t_cmd;
        end
        chk(w[1] - w[0], 4);
        chk(w[2], w[0]);
        $display("test powerdown done");
    endtask

    task automatic final_report();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock_in);
        reset_in <= 1'b0;
        t_rst();
        t_lat();
        t_pad();
        t_dll();
        t_pwr();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clock_in);
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
